// File: pkg/dmc_pkg.sv
// Constants and types for the single DMA channel transfer controller.
// Assumes a 16-bit peripheral bus and a 2 KB dual port RAM window.
`default_nettype none
package dmc_pkg;
    localparam int unsigned CNT_W       = 10;
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned RAMA_W      = 10;
    // Bytes of RAM reachable by the channel
    localparam logic [15:0] RAM_BYTES   = 16'h0800;
    // Control word field positions
    localparam int unsigned CTL_EN      = 15;
    localparam int unsigned CTL_SIZE    = 14;
    localparam int unsigned CTL_DIR     = 13;
    localparam int unsigned CTL_HALF    = 12;
    localparam int unsigned CTL_AM_HI   = 5;
    localparam int unsigned CTL_AM_LO   = 4;
    localparam int unsigned CTL_PP      = 1;
    localparam int unsigned CTL_ONE     = 0;
    localparam logic [15:0] CTL_RESET   = 16'h0000;
    // Addressing field encodings
    localparam logic [1:0]  AM_POSTINC  = 2'h0;
    localparam logic [1:0]  AM_STATIC   = 2'h1;
    // Post-increment steps
    localparam logic [15:0] STEP_WORD   = 16'h0002;
    localparam logic [15:0] STEP_BYTE   = 16'h0001;
    // Buffer entry: dir, oob, byte, address, data
    localparam int unsigned ENT_W       = 3 + ADDR_W + DATA_W;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_READ = 1'h1
    } dmc_state_t;
endpackage : dmc_pkg
`default_nettype wire

// File: src/dmc_buf2.sv
// Two-entry FIFO with valid/ready on both sides.
// Assumes a synchronous active-high reset on the shared clock.
`default_nettype none
module dmc_buf2 #(
    parameter int unsigned W = 8
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } dmc_buf_t;

    dmc_buf_t s_r;
    dmc_buf_t s_nxt;
    logic     push;
    logic     pop;

    assign in_ready  = (s_r.cnt != 2'h2);
    assign out_valid = (s_r.cnt != 2'h0);
    assign out_data  = s_r.mem[s_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = ~s_r.wp;
        end
        if (pop)
        begin
            s_nxt.rp = ~s_r.rp;
        end
        s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule : dmc_buf2
`default_nettype wire

// File: src/dmc_channel.sv
// One DMA channel: request service, RAM addressing, counting, interrupt flag.
// Assumes read data valid in the same cycle as the registered strobe on both the RAM and the peripheral bus.
`default_nettype none
//Contract
//[R1] Block ends after count plus one elements
//[R2] Count is elements, not scaled by size
//[R3] Out-of-range RAM: drop writes, read zero
//[R4] Word or byte elements; words stay aligned
//[R5] Word size: post-increment by two
//[R6] Byte size: post-increment by one
//[R7] Direction clear: peripheral to RAM
//[R8] Direction set: RAM to peripheral
//[R9] Each channel moves one direction only
//[R10] Interrupt at completion or at midpoint
//[R11] Midpoint mode: no interrupt at completion
//[R12] Midpoint after (count+2)/2 transfers, rounded
//[R13] Midpoint select sampled live each element
//[R14] Interrupt sets flag; software clears it
//[R15] Software enables interrupt to reach CPU
//[R16] Manual trigger forces one element
//[R17] One-shot, continuous, ping-pong buffer swap
//[R18] Addressing field: 00 increment, 01 static
//[R19] Indirect: base ORed with peripheral address
//[R20] Element counter cleared at block start
module dmc_channel (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic [15:0]                channel_control_reg,
    input  wire logic [dmc_pkg::CNT_W-1:0]  transfer_count_reg,
    input  wire logic [dmc_pkg::ADDR_W-1:0] peripheral_address_reg,
    input  wire logic [dmc_pkg::ADDR_W-1:0] start_offset_primary,
    input  wire logic [dmc_pkg::ADDR_W-1:0] start_offset_secondary,
    input  wire logic                       dma_req,
    input  wire logic                       manual_force,
    input  wire logic [dmc_pkg::ADDR_W-1:0] per_ind_addr,
    input  wire logic [dmc_pkg::DATA_W-1:0] per_rdata,
    input  wire logic                       per_ready,
    output logic [dmc_pkg::ADDR_W-1:0]      per_addr,
    output logic                            per_re,
    output logic                            per_we,
    output logic [dmc_pkg::DATA_W-1:0]      per_wdata,
    input  wire logic [dmc_pkg::DATA_W-1:0] ram_rdata,
    output logic [dmc_pkg::RAMA_W-1:0]      ram_addr,
    output logic                            ram_re,
    output logic                            ram_we,
    output logic [1:0]                      ram_be,
    output logic [dmc_pkg::DATA_W-1:0]      ram_wdata,
    input  wire logic                       channel_irq_enable,
    input  wire logic                       irq_flag_clr,
    output logic                            channel_irq_flag,
    output logic                            irq_out,
    output logic                            busy
);
    import dmc_pkg::*;

    typedef struct packed {
        dmc_state_t          st;
        logic                run;
        logic                en_q;
        logic                sel_b;
        logic [ADDR_W-1:0]   cur;
        logic [CNT_W-1:0]    ecnt;
        logic [ADDR_W-1:0]   ea;
        logic                oob;
        logic                dir;
        logic                byt;
        logic [ADDR_W-1:0]   paddr;
        logic                pre;
        logic                pwe;
        logic [DATA_W-1:0]   pwd;
        logic [RAMA_W-1:0]   raddr;
        logic                rre;
        logic                rwe;
        logic [1:0]          rbe;
        logic [DATA_W-1:0]   rwd;
        logic                flag;
        logic                irq;
    } dmc_chan_t;

    dmc_chan_t         s_r;
    dmc_chan_t         s_nxt;
    logic              c_en;
    logic              c_byte;
    logic              c_dir;
    logic              c_half;
    logic [1:0]        c_am;
    logic              c_pp;
    logic              c_one;
    logic              issue;
    logic              last;
    logic              mid;
    logic              evt;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] ea;
    logic              b_in_valid;
    logic              b_in_ready;
    logic [ENT_W-1:0]  b_in_data;
    logic              b_out_valid;
    logic              b_out_ready;
    logic [ENT_W-1:0]  b_out_data;
    logic [DATA_W-1:0] rd_val;

    // Transfer number at which the midpoint falls, for count+1 odd or even
    function automatic logic [CNT_W:0] half_point(input logic [CNT_W-1:0] n);
        logic [CNT_W:0] t;
        t = {1'b0, n} + {{CNT_W{1'b0}}, 1'b1} + {{CNT_W{1'b0}}, 1'b1};
        return {1'b0, t[CNT_W:1]};
    endfunction : half_point

    function automatic logic out_of_range(input logic [ADDR_W-1:0] a);
        return (a >= RAM_BYTES);
    endfunction : out_of_range

    assign c_en   = channel_control_reg[CTL_EN];
    assign c_byte = channel_control_reg[CTL_SIZE];
    assign c_dir  = channel_control_reg[CTL_DIR];
    assign c_half = channel_control_reg[CTL_HALF];
    assign c_am   = channel_control_reg[CTL_AM_HI:CTL_AM_LO];
    assign c_pp   = channel_control_reg[CTL_PP];
    assign c_one  = channel_control_reg[CTL_ONE];
    assign base   = s_r.sel_b ? start_offset_secondary : start_offset_primary;

    // [R16] Manual trigger as request
    assign issue = (s_r.st == ST_IDLE) && s_r.run && c_en && b_in_ready
                   && (dma_req || manual_force);

    // [R19] Base ORed with peripheral address
    always_comb
    begin
        ea = c_am[1] ? (base | per_ind_addr) : s_r.cur;
        // [R4] Words stay aligned
        if (!c_byte)
        begin
            ea[0] = 1'b0;
        end
    end

    // [R1] Count plus one elements
    assign last = (s_r.ecnt == transfer_count_reg);
    // [R12] Midpoint transfer number
    assign mid  = ({1'b0, s_r.ecnt} + {{CNT_W{1'b0}}, 1'b1})
                  == half_point(transfer_count_reg);
    // [R10] [R11] [R13] Live half select
    assign evt  = issue && (c_half ? mid : last);

    // [R3] Out-of-range reads give zero
    always_comb
    begin
        rd_val = '0;
        if (!s_r.oob)
        begin
            if (!s_r.byt)
            begin
                rd_val = ram_rdata;
            end
            else
            begin
                rd_val[7:0] = s_r.ea[0] ? ram_rdata[15:8] : ram_rdata[7:0];
            end
        end
    end

    assign b_in_valid  = (s_r.st == ST_READ);
    assign b_in_data   = {s_r.dir, s_r.oob, s_r.byt, s_r.ea,
                          s_r.dir ? rd_val : per_rdata};
    // Peripheral back-pressure stalls draining; RAM always accepts
    assign b_out_ready = b_out_data[ENT_W-1] ? per_ready : 1'b1;

    dmc_buf2 #(
        .W (ENT_W)
    ) u_buf (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (b_in_valid),
        .in_ready  (b_in_ready),
        .in_data   (b_in_data),
        .out_valid (b_out_valid),
        .out_ready (b_out_ready),
        .out_data  (b_out_data)
    );

    always_comb
    begin
        logic [DATA_W-1:0] d;
        logic [ADDR_W-1:0] a;
        d = b_out_data[DATA_W-1:0];
        a = b_out_data[DATA_W+ADDR_W-1:DATA_W];
        s_nxt = s_r;
        s_nxt.en_q = c_en;
        s_nxt.pre  = 1'b0;
        s_nxt.pwe  = 1'b0;
        s_nxt.rre  = 1'b0;
        s_nxt.rwe  = 1'b0;
        // One-shot or continuous arm on enable
        if (c_en && !s_r.en_q)
        begin
            s_nxt.run   = 1'b1;
            s_nxt.sel_b = 1'b0;
            s_nxt.cur   = start_offset_primary;
            s_nxt.ecnt  = '0;
        end
        else if (!c_en)
        begin
            s_nxt.run = 1'b0;
        end
        case (s_r.st)
            ST_IDLE:
            begin
                if (issue)
                begin
                    s_nxt.st   = ST_READ;
                    s_nxt.ea   = ea;
                    s_nxt.oob  = out_of_range(ea);
                    s_nxt.dir  = c_dir;
                    s_nxt.byt  = c_byte;
                    // [R9] One direction per channel
                    if (!c_dir)
                    begin
                        // [R7] Read peripheral first
                        s_nxt.pre   = 1'b1;
                        s_nxt.paddr = peripheral_address_reg;
                    end
                    else
                    begin
                        // [R8] Read RAM first
                        s_nxt.rre   = !out_of_range(ea);
                        s_nxt.raddr = ea[RAMA_W:1];
                    end
                    // [R18] Addressing mode select
                    if (c_am == AM_POSTINC)
                    begin
                        // [R5] [R6] Step by size
                        s_nxt.cur = ea + (c_byte ? STEP_BYTE : STEP_WORD);
                    end
                    else if (c_am == AM_STATIC)
                    begin
                        s_nxt.cur = ea;
                    end
                    else
                    begin
                        s_nxt.cur = ea;
                    end
                    // [R2] Count elements unscaled
                    s_nxt.ecnt = s_r.ecnt + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (last)
                    begin
                        // [R20] Counter cleared per block
                        s_nxt.ecnt = '0;
                        // [R17] Ping-pong and one-shot
                        s_nxt.sel_b = c_pp ? ~s_r.sel_b : s_r.sel_b;
                        s_nxt.cur   = (c_pp && !s_r.sel_b) ? start_offset_secondary
                                                           : start_offset_primary;
                        if (c_one && (!c_pp || s_r.sel_b))
                        begin
                            s_nxt.run = 1'b0;
                        end
                    end
                end
            end
            ST_READ:
            begin
                s_nxt.st = ST_IDLE;
            end
            default:
            begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        if (b_out_valid && b_out_ready)
        begin
            if (b_out_data[ENT_W-1])
            begin
                s_nxt.pwe   = 1'b1;
                s_nxt.paddr = peripheral_address_reg;
                s_nxt.pwd   = d;
            end
            else
            begin
                // [R3] Out-of-range writes dropped
                s_nxt.rwe   = !b_out_data[ENT_W-2];
                s_nxt.raddr = a[RAMA_W:1];
                s_nxt.rbe   = !b_out_data[ENT_W-3] ? 2'h3 : (a[0] ? 2'h2 : 2'h1);
                s_nxt.rwd   = b_out_data[ENT_W-3] ? {d[7:0], d[7:0]} : d;
            end
        end
        // [R14] Set wins over clear
        s_nxt.flag = (s_r.flag && !irq_flag_clr) || evt;
        // [R15] Enable gates the request
        s_nxt.irq  = s_nxt.flag && channel_irq_enable;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_r    <= '0;
            s_r.st <= ST_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign per_addr         = s_r.paddr;
    assign per_re           = s_r.pre;
    assign per_we           = s_r.pwe;
    assign per_wdata        = s_r.pwd;
    assign ram_addr         = s_r.raddr;
    assign ram_re           = s_r.rre;
    assign ram_we           = s_r.rwe;
    assign ram_be           = s_r.rbe;
    assign ram_wdata        = s_r.rwd;
    assign channel_irq_flag = s_r.flag;
    assign irq_out          = s_r.irq;
    assign busy             = s_r.run;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_word_inc;
        issue && c_am == AM_POSTINC && !c_byte && !last;
    endsequence

    property p_zero_count; // [R1]
        issue && transfer_count_reg == '0 && !c_half |=> channel_irq_flag;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("count 0 no irq"); // [R1]

    property p_word_step;
        s_word_inc |=> s_r.cur == $past(ea) + STEP_WORD;
    endproperty
    a_word_step: assert property (p_word_step) else $error("word step"); // [R5]

    property p_byte_step;
        issue && c_am == AM_POSTINC && c_byte && !last |=> s_r.cur == $past(ea) + STEP_BYTE;
    endproperty
    a_byte_step: assert property (p_byte_step) else $error("byte step"); // [R6]

    property p_oob_zero;
        s_r.st == ST_READ && s_r.dir && s_r.oob |-> b_in_data[DATA_W-1:0] == '0;
    endproperty
    a_oob_zero: assert property (p_oob_zero) else $error("oob read nonzero"); // [R3]

    property p_half_irq;
        issue && c_half && mid |=> channel_irq_flag;
    endproperty
    a_half_irq: assert property (p_half_irq) else $error("no midpoint irq"); // [R12]

    property p_half_no_full;
        issue && c_half && last && !mid && !s_r.flag |=> !channel_irq_flag;
    endproperty
    a_half_no_full: assert property (p_half_no_full) else $error("full irq in half"); // [R11]

    property p_cnt_clear;
        issue && last |=> s_r.ecnt == '0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared"); // [R20]

    sequence s_per_read;
        issue && !c_dir;
    endsequence
    property p_dir_in;
        s_per_read |=> per_re && !ram_re && b_in_valid;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("dir 0 read wrong"); // [R7]

    property p_set_wins;
        evt && irq_flag_clr |=> channel_irq_flag && irq_out == $past(channel_irq_enable);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost"); // [R14]

    property p_pingpong;
        issue && last && c_pp |=> s_r.sel_b != $past(s_r.sel_b);
    endproperty
    a_pingpong: assert property (p_pingpong) else $error("no buffer swap"); // [R17]
endmodule : dmc_channel
`default_nettype wire

// File: bench/dmc_far.sv
// Far-side model: a peripheral data register and the dual port RAM.
// Assumes one-cycle read strobes and a stall input driven by the bench.
`default_nettype none
module dmc_far (
    input  wire logic        mclk,
    input  wire logic        stall,
    input  wire logic [9:0]  ram_addr,
    input  wire logic        ram_re,
    input  wire logic        ram_we,
    input  wire logic [1:0]  ram_be,
    input  wire logic [15:0] ram_wdata,
    output logic [15:0]      ram_rdata,
    input  wire logic        per_re,
    output logic [15:0]      per_rdata,
    output logic             per_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [0:2047];
    logic [15:0] rd_cnt = 16'h0000;
    logic [15:0] wr_cnt = 16'h0000;
    initial
    begin
        for (int i = 0; i < 2048; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end
    assign per_ready = !stall;
    // The strobe already stands one cycle after the take, so data answers it at once
    // Lines show the inverse when not strobed, so stale data never matches
    assign ram_rdata = ram_re ? {mem[{ram_addr, 1'h1}], mem[{ram_addr, 1'h0}]}
                              : ~{mem[{ram_addr, 1'h1}], mem[{ram_addr, 1'h0}]};
    assign per_rdata = per_re ? (16'hc000 | rd_cnt) : ~(16'hc000 | rd_cnt);
    always @(posedge mclk)
    begin
        if (per_re)
            rd_cnt <= rd_cnt + 16'h0001;
        if (ram_we)
            wr_cnt <= wr_cnt + 16'h0001;
        if (ram_we && ram_be[0])
            mem[{ram_addr, 1'h0}] <= ram_wdata[7:0];
        if (ram_we && ram_be[1])
            mem[{ram_addr, 1'h1}] <= ram_wdata[15:8];
    end
endmodule : dmc_far
`default_nettype wire

// File: bench/dmc_channel_tb.sv
// Self-checking bench for one DMA channel against the far-side model.
// Assumes the hand-over timing: strobes one cycle after a take.
`default_nettype none
module dmc_channel_tb;
    import dmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'h0, sys_rst = 1'h1, dma_req = 1'h0, manual_force = 1'h0;
    logic        irq_en = 1'h0, flag_clr = 1'h0, stall = 1'h0, stall_en = 1'h0;
    logic [15:0] ctl = 16'h0000, pad = 16'h0000, sa = 16'h0000, sb = 16'h0000;
    logic [15:0] ind = 16'h0000;
    logic [9:0]  cnt = 10'h000, ram_addr;
    logic [15:0] per_rdata, per_addr, per_wdata, ram_rdata, ram_wdata;
    logic [1:0]  ram_be;
    logic        per_ready, per_re, per_we, ram_re, ram_we, flag, irq_out, busy;
    logic [15:0] wq[$];
    int          failures = 0, cmp_count = 0, cyc = 0, base;

    always #50 mclk = ~mclk;

    dmc_channel uut (.mclk, .sys_rst, .channel_control_reg(ctl), .transfer_count_reg(cnt),
        .peripheral_address_reg(pad), .start_offset_primary(sa), .start_offset_secondary(sb),
        .dma_req, .manual_force, .per_ind_addr(ind), .per_rdata, .per_ready,
        .per_addr, .per_re, .per_we, .per_wdata, .ram_rdata, .ram_addr, .ram_re, .ram_we,
        .ram_be, .ram_wdata, .channel_irq_enable(irq_en), .irq_flag_clr(flag_clr),
        .channel_irq_flag(flag), .irq_out, .busy);

    dmc_far u_far (.mclk, .stall, .ram_addr, .ram_re, .ram_we, .ram_be, .ram_wdata,
        .ram_rdata, .per_re, .per_rdata, .per_ready);

    always @(posedge mclk)
    begin
        stall <= stall_en ? ($urandom % 4 != 0) : 1'h0;
        if (per_we)
            wq.push_back(per_wdata);
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            failures++;
        end
    endtask : check

    function automatic int mid(input int n);
        return ((n + 1) % 2 == 0) ? (n + 1) / 2 : (n + 2) / 2;
    endfunction : mid

    function automatic logic [15:0] word(input int a);
        return {u_far.mem[a + 1], u_far.mem[a]};
    endfunction : word

    // Enable must see a rising edge to arm
    task automatic arm(input logic [15:0] c, input logic [9:0] n, input logic [15:0] s);
        @(posedge mclk);
        ctl <= c;
        cnt <= n;
        sa <= s;
        sb <= 16'($urandom);
        pad <= 16'($urandom);
        @(posedge mclk);
        ctl[15] <= 1'h1;
        repeat (2) @(posedge mclk);
    endtask : arm

    // Request held until its strobe shows, then dropped
    task automatic elem(input bit frc, input bit oob, input bit expf);
        int t;
        @(posedge mclk);
        if (frc)
            manual_force <= 1'h1;
        else
            dma_req <= 1'h1;
        t = 0;
        do
        begin
            @(negedge mclk);
            t++;
        end
        while (!(per_re || ram_re || (oob && per_we)) && t < 300);
        check("take", 16'(t < 300), 16'h0001);
        check("flag", 16'(flag), 16'(expf));
        @(posedge mclk);
        dma_req <= 1'h0;
        manual_force <= 1'h0;
    endtask : elem

    task automatic clr();
        @(posedge mclk);
        flag_clr <= 1'h1;
        @(posedge mclk);
        flag_clr <= 1'h0;
    endtask : clr

    initial
    begin
        int n;
        int t;
        void'($urandom(32'h32cb));
        repeat (4) @(posedge mclk);
        sys_rst <= 1'h0;
        @(negedge mclk);
        check("busy", 16'(busy), 16'h0000);
        check("irq", 16'(irq_out), 16'h0000);
        n = 2 + $urandom % 4;
        arm(16'h0000, 10'(n), {6'h00, 9'($urandom), 1'h0});
        base = u_far.rd_cnt;
        for (int i = 1; i <= n + 1; i++)
            elem(0, 0, i == n + 1);
        repeat (4) @(posedge mclk);
        for (int i = 0; i <= n; i++)
            check("word", word(sa + 2 * i), 16'hc000 | 16'(base + i));
        irq_en <= 1'h1;
        repeat (2) @(negedge mclk);
        check("irq on", 16'(irq_out), 16'h0001);
        @(posedge mclk);
        irq_en <= 1'h0;
        repeat (2) @(negedge mclk);
        check("irq off", 16'(irq_out), 16'h0000);
        clr();
        arm(16'h4000, 10'h004, {6'h00, 9'($urandom), 1'h1});
        base = u_far.rd_cnt;
        for (int i = 1; i <= 5; i++)
            elem(0, 0, i == 5);
        repeat (4) @(posedge mclk);
        for (int i = 0; i <= 4; i++)
            check("byte", 16'(u_far.mem[sa + i]), 16'(8'(base + i)));
        clr();
        for (int k = 5; k <= 6; k++)
        begin
            arm(16'h1010, 10'(k), {6'h00, 9'($urandom), 1'h0});
            base = u_far.rd_cnt;
            for (int b = 0; b < 2; b++)
                for (int i = 1; i <= k + 1; i++)
                begin
                    elem(0, 0, i == mid(k) || (b == 1 && i == k + 1));
                    if (i == mid(k) || i == k + 1)
                        clr();
                    if (i == mid(k) && b == 1)
                        ctl[12] <= 1'h0;
                end
            repeat (4) @(posedge mclk);
            check("static", word(sa), 16'hc000 | 16'(base + 2 * k + 1));
        end
        arm(16'h2000, 10'h005, {6'h00, 9'($urandom), 1'h0});
        base = u_far.rd_cnt;
        wq.delete();
        stall_en <= 1'h1;
        for (int i = 1; i <= 6; i++)
            elem(1, 0, i == 6);
        for (t = 0; t < 400 && wq.size() < 6; t++)
            @(posedge mclk);
        stall_en <= 1'h0;
        for (int i = 0; i < 6; i++)
            check("per word", wq[i], word(sa + 2 * i));
        check("no reads", u_far.rd_cnt, 16'(base));
        check("per addr", per_addr, pad);
        clr();
        arm(16'h2001, 10'h000, 16'h0800 | {5'h00, 10'($urandom), 1'h0});
        wq.delete();
        elem(0, 1, 1);
        repeat (6) @(posedge mclk);
        check("oob read", (wq.size() == 1) ? wq[0] : 16'hffff, 16'h0000);
        check("one-shot", 16'(busy), 16'h0000);
        clr();
        base = u_far.wr_cnt;
        arm(16'h0001, 10'h000, 16'h0800);
        elem(0, 0, 1);
        repeat (6) @(posedge mclk);
        check("oob write", u_far.wr_cnt, 16'(base));
        // Ping-pong one-shot: A then B, then disarm; second take meets a held clear
        clr();
        arm(16'h0003, 10'h000, {6'h00, 9'($urandom), 1'h0});
        sb <= sa | 16'h0400;
        base = u_far.rd_cnt;
        elem(0, 0, 1);
        flag_clr <= 1'h1;
        elem(0, 0, 1);
        flag_clr <= 1'h0;
        repeat (4) @(posedge mclk);
        check("ping", word(sa), 16'hc000 | 16'(base));
        check("pong", word(sa | 16'h0400), 16'hc000 | 16'(base + 1));
        check("pp one-shot", 16'(busy), 16'h0000);
        // Indirect: base ORed with the peripheral's low address
        ind <= 16'h0006;
        arm(16'h0020, 10'h000, 16'h0100);
        base = u_far.rd_cnt;
        elem(0, 0, 1);
        repeat (4) @(posedge mclk);
        check("indirect", word(16'h0106), 16'hc000 | 16'(base));
        summarize();
    end
endmodule : dmc_channel_tb
`default_nettype wire
